/* doim_pkg.sv */
package doim_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 4;
	// Register indices (word address on the plain register port)
	localparam logic [3:0] ADDR_TWO_CH_DRIVE = 4'h0;
	localparam logic [3:0] ADDR_TWO_CH_FLAGS = 4'h1;
	localparam logic [3:0] ADDR_TWO_CH_CODED_DRIVE = 4'h2;
	localparam logic [3:0] ADDR_TWO_CH_CODES = 4'h3;
	localparam logic [3:0] ADDR_FOUR_CH_DRIVE = 4'h4;
	localparam logic [3:0] ADDR_FOUR_CH_DIAG_DRIVE = 4'h5;
	localparam logic [3:0] ADDR_FOUR_CH_FLAGS = 4'h6;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Field widths
	localparam int unsigned TWO_CH = 2;
	localparam int unsigned FOUR_CH = 4;
	// Two-bit fault codes
	typedef enum logic [1:0]
	{
		DOIM_CODE_NORMAL = 2'b00,
		DOIM_CODE_OPEN_OR_HIGH = 2'b01,
		DOIM_CODE_GND_OR_OVL = 2'b10,
		DOIM_CODE_RESERVED = 2'b11
	} doim_code_t;
	// Per-channel condition sensed at the output stage
	typedef struct packed
	{
		logic overload;
		logic short_gnd;
		logic short_supply;
		logic open_wire;
	} doim_sense_t;
	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} doim_bus_req_t;
endpackage

/* doim_top.sv */
// Summary of operation
// - Every diagnosing output channel raises a fault flag on overload, short or open.
// - Faults go back in the input image; drive comes only from output image.
// - Flag of channel 1 in bit 0, next channels upward, unused bits zero.
// - Two-channel drive: bit 0 drives channel 1, bit 1 channel 2, rest ignored.
// - Coded variant: two-bit code per channel, ch1 in bits 1:0, ch2 in 3:2.
// - Code 00 normal, 01 open load or short to supply, 10 ground short/overload.
// - Coded variant drive: bits 0 and 1 drive channels, bits 2 and 3 ignored.
// - Four-channel drive: bit n drives channel n+1, bits 4 to 7 ignored.
// - Four-channel diagnosing: flags in bits 0 to 3, drive from bits 0 to 3.
// - Single-bit flag: 0 means no error, 1 means overload, short or open.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module doim_top
	import doim_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire doim_pkg::doim_bus_req_t bus_req,
	output logic [doim_pkg::DATA_W-1:0] rdata,
	input wire doim_pkg::doim_sense_t [1:0] sense_two,
	input wire doim_pkg::doim_sense_t [1:0] sense_coded,
	input wire doim_pkg::doim_sense_t [3:0] sense_diag4,
	output logic [1:0] drive_two,
	output logic [1:0] drive_coded,
	output logic [3:0] drive_four,
	output logic [3:0] drive_diag4
);
	import doim_pkg::*;

	// Single-bit flag: any of the four sensed fault conditions
	function automatic logic fault_any(input doim_sense_t s);
		fault_any = s.overload | s.short_gnd | s.short_supply | s.open_wire;
	endfunction

	// Ground short and overload take priority; 11 is never produced
	function automatic doim_code_t fault_code(input doim_sense_t s);
		if (s.overload | s.short_gnd)
			fault_code = DOIM_CODE_GND_OR_OVL;
		else if (s.open_wire | s.short_supply)
			fault_code = DOIM_CODE_OPEN_OR_HIGH;
		else
			fault_code = DOIM_CODE_NORMAL;
	endfunction

	logic [1:0] two_drive_r;
	logic [1:0] coded_drive_r;
	logic [3:0] four_drive_r;
	logic [3:0] diag4_drive_r;
	logic [1:0] two_flags_r;
	logic [3:0] codes_r;
	logic [3:0] diag4_flags_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [1:0] two_flags_nxt;
	logic [3:0] codes_nxt;
	logic [3:0] diag4_flags_nxt;
	wire wr_two = bus_req.wr && bus_req.addr == ADDR_TWO_CH_DRIVE;
	wire wr_coded = bus_req.wr && bus_req.addr == ADDR_TWO_CH_CODED_DRIVE;
	wire wr_four = bus_req.wr && bus_req.addr == ADDR_FOUR_CH_DRIVE;
	wire wr_diag4 = bus_req.wr && bus_req.addr == ADDR_FOUR_CH_DIAG_DRIVE;

	// Flags recomputed every cycle, so they clear on the first clock edge after the fault goes
	assign two_flags_nxt = {fault_any(sense_two[1]),
		fault_any(sense_two[0])};
	assign codes_nxt = {fault_code(sense_coded[1]),
		fault_code(sense_coded[0])};
	assign diag4_flags_nxt = {fault_any(sense_diag4[3]), fault_any(sense_diag4[2]),
		fault_any(sense_diag4[1]), fault_any(sense_diag4[0])};

	// Read mux: drive registers read back only their used bits
	always_comb
	begin
		rdata_nxt = UNMAPPED_READ;
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				ADDR_TWO_CH_DRIVE: rdata_nxt = {6'h00, two_drive_r};
				ADDR_TWO_CH_FLAGS: rdata_nxt = {6'h00, two_flags_r};
				ADDR_TWO_CH_CODED_DRIVE: rdata_nxt = {6'h00, coded_drive_r};
				ADDR_TWO_CH_CODES: rdata_nxt = {4'h0, codes_r};
				ADDR_FOUR_CH_DRIVE: rdata_nxt = {4'h0, four_drive_r};
				ADDR_FOUR_CH_DIAG_DRIVE: rdata_nxt = {4'h0, diag4_drive_r};
				ADDR_FOUR_CH_FLAGS: rdata_nxt = {4'h0, diag4_flags_r};
				default: rdata_nxt = UNMAPPED_READ;
			endcase
		end
	end

	// Status registers are read only; writes to them are dropped
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			two_drive_r <= DRIVE_RESET[1:0];
			coded_drive_r <= DRIVE_RESET[1:0];
			four_drive_r <= DRIVE_RESET[3:0];
			diag4_drive_r <= DRIVE_RESET[3:0];
			two_flags_r <= 2'h0;
			codes_r <= 4'h0;
			diag4_flags_r <= 4'h0;
			rdata_r <= UNMAPPED_READ;
		end
		else
		begin
			if (wr_two)
				two_drive_r <= bus_req.wdata[1:0];
			if (wr_coded)
				coded_drive_r <= bus_req.wdata[1:0];
			if (wr_four)
				four_drive_r <= bus_req.wdata[3:0];
			if (wr_diag4)
				diag4_drive_r <= bus_req.wdata[3:0];
			two_flags_r <= two_flags_nxt;
			codes_r <= codes_nxt;
			diag4_flags_r <= diag4_flags_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign drive_two = two_drive_r;
	assign drive_coded = coded_drive_r;
	assign drive_four = four_drive_r;
	assign drive_diag4 = diag4_drive_r;
	assign rdata = rdata_r;
endmodule
`default_nettype wire

/* doim_stage.sv */
`timescale 1ns/100ps
`default_nettype none
module doim_stage (
	input wire logic [31:0] inj,
	output logic [31:0] sense
);
	// Any mix of faults, several at once too
	assign sense = inj;
endmodule
`default_nettype wire

/* doim_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module doim_properties (
	input wire logic mclk,
	input wire logic resetn,
	input wire doim_pkg::doim_bus_req_t bus_req,
	input wire logic [7:0] rdata,
	input wire doim_pkg::doim_sense_t [1:0] sense_two,
	input wire doim_pkg::doim_sense_t [1:0] sense_coded,
	input wire doim_pkg::doim_sense_t [3:0] sense_diag4,
	input wire logic [1:0] drive_two,
	input wire logic [1:0] drive_coded,
	input wire logic [3:0] drive_four,
	input wire logic [3:0] drive_diag4
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic [3:0] a = bus_req.addr;
	wire logic [3:0] f = {|sense_diag4[3], |sense_diag4[2], |sense_diag4[1],
		|sense_diag4[0]};
	wire logic [1:0] g = {|sense_coded[1][3:2], |sense_coded[0][3:2]};
	wire logic [1:0] o = {|sense_coded[1][1:0], |sense_coded[0][1:0]} & ~g;
	wire logic [1:0] f2 = {|sense_two[1], |sense_two[0]};
	wire logic [3:0] c = {g[1], o[1], g[0], o[0]};
	a_two_drive: assert property (bus_req.wr && a == 4'h0 |=>
		drive_two == $past(bus_req.wdata[1:0])) else $error("two drive");
	a_coded_drive: assert property (bus_req.wr && a == 4'h2 |=>
		drive_coded == $past(bus_req.wdata[1:0])) else $error("coded drive");
	a_four_drive: assert property (bus_req.wr && a == 4'h4 |=>
		drive_four == $past(bus_req.wdata[3:0])) else $error("four drive");
	a_four_hold: assert property (!(bus_req.wr && a == 4'h4) |=>
		$stable(drive_four)) else $error("four hold");
	a_code_read: assert property (bus_req.rd && a == 4'h3 |=>
		rdata == {4'h0, $past(c, 2)}) else $error("code read");
	a_flag_read: assert property (bus_req.rd && a == 4'h6 |=>
		rdata == {4'h0, $past(f, 2)}) else $error("flag read");
	a_unmapped_read: assert property (bus_req.rd && a > 4'h6 |=>
		rdata == 8'h00) else $error("unmapped read");
	a_rdata_idle: assert property (!bus_req.rd |=>
		rdata == 8'h00) else $error("idle read");
	a_diag4_drive: assert property (bus_req.wr && a == 4'h5 |=>
		drive_diag4 == $past(bus_req.wdata[3:0])) else $error("diag4 drive");
	a_two_flag_read: assert property (bus_req.rd && a == 4'h1 |=>
		rdata == {6'h00, $past(f2, 2)}) else $error("two flag read");
	a_code_reserved: assert property (bus_req.rd && a == 4'h3 |=>
		rdata[1:0] != 2'b11 && rdata[3:2] != 2'b11) else $error("reserved code");
endmodule
bind doim_top doim_properties chk (.*);
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import doim_pkg::*;
	logic mclk = 0, resetn = 0;
	logic [31:0] inj = 0, r, v;
	logic [3:0] e = 4'h0, e_four = 4'h0;
	logic [1:0] e_two = 2'h0, e_coded = 2'h0;
	logic [7:0] e_rd = 8'h00;
	doim_bus_req_t q = '0, nq;
	integer seed = 32'h1EAC, failures = 0, check_count = 0;
	wire logic [3:0] dr, d4;
	wire logic [1:0] d2, dc;
	wire logic [7:0] rd;
	wire logic [31:0] s;
	doim_stage stg (.inj(inj), .sense(s));
	doim_top dut (.mclk(mclk), .resetn(resetn), .bus_req(q), .rdata(rd),
		.sense_two(s[7:0]), .sense_coded(s[15:8]), .sense_diag4(s[31:16]),
		.drive_two(d2), .drive_coded(dc), .drive_four(d4), .drive_diag4(dr));
	initial forever #12.5 mclk = ~mclk;
	// Nibble order per channel: overload, ground short, supply short, open
	function automatic logic flag(input logic [3:0] n);
		flag = |n;
	endfunction
	function automatic logic [1:0] code(input logic [3:0] n);
		if (n[3] | n[2])
			code = 2'b10;
		else if (n[1] | n[0])
			code = 2'b01;
		else
			code = 2'b00;
	endfunction
	function automatic logic [7:0] exp_read(input doim_bus_req_t b,
		input logic [31:0] x);
		exp_read = 8'h00;
		if (b.rd)
			case (b.addr)
				ADDR_TWO_CH_DRIVE: exp_read = {6'h00, e_two};
				ADDR_TWO_CH_FLAGS: exp_read = {6'h00, flag(x[7:4]), flag(x[3:0])};
				ADDR_TWO_CH_CODED_DRIVE: exp_read = {6'h00, e_coded};
				ADDR_TWO_CH_CODES: exp_read = {4'h0, code(x[15:12]), code(x[11:8])};
				ADDR_FOUR_CH_DRIVE: exp_read = {4'h0, e_four};
				ADDR_FOUR_CH_DIAG_DRIVE: exp_read = {4'h0, e};
				ADDR_FOUR_CH_FLAGS: exp_read = {4'h0, flag(x[31:28]),
					flag(x[27:24]), flag(x[23:20]), flag(x[19:16])};
				default: exp_read = 8'h00;
			endcase
	endfunction
	task automatic check(input string n, input logic [7:0] x, input logic [7:0] g);
		check_count++;
		if (x !== g)
		begin
			failures++;
			$display("mismatch %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic conclude();
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge mclk);
		resetn <= 1;
		for (int k = 0; k < 600; k++)
		begin
			@(posedge mclk);
			r = $random(seed);
			v = inj;
			// One drive bit per channel in each byte
			// Digital bytes only, no analog data ahead
			nq = {r[13:1], r[0] & ~r[1]};
			if (k < 16)
				nq = {k[3:0], 8'hFF, 1'b0, 1'b1};
			q <= nq;
			// Faults are injected regardless of drive, all at once when r[31] is set, so flag and data bits both vary
			inj <= r[31] ? '1 : $random(seed) & $random(seed);
			@(negedge mclk);
			check("drive_diag4", {4'h0, e}, {4'h0, dr});
			check("drive_two", {6'h00, e_two}, {6'h00, d2});
			check("drive_coded", {6'h00, e_coded}, {6'h00, dc});
			check("drive_four", {4'h0, e_four}, {4'h0, d4});
			check("rdata", e_rd, rd);
			e_rd = exp_read(nq, v);
			if (nq.wr && nq.addr == ADDR_TWO_CH_DRIVE) e_two = nq.wdata[1:0];
			if (nq.wr && nq.addr == ADDR_TWO_CH_CODED_DRIVE) e_coded = nq.wdata[1:0];
			if (nq.wr && nq.addr == ADDR_FOUR_CH_DRIVE) e_four = nq.wdata[3:0];
			if (nq.wr && nq.addr == ADDR_FOUR_CH_DIAG_DRIVE) e = nq.wdata[3:0];
		end
		conclude();
	end
endmodule
`default_nettype wire
